// ===== hw/status_regs_cfg.svh
`ifndef STATUS_REGS_CFG_SVH
`define STATUS_REGS_CFG_SVH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define OFS_FAULT_IRQ3 7'h6d
`define OFS_EXC_COUNT 7'h6e
`define OFS_NVM_ECC 7'h70
`define OFS_REVISION 7'h73
`define OFS_GAIN_CODE 7'h78
`define OFS_SELFTEST 7'h79
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define BIT_OSC_FAIL 2
`define BIT_COIL_FAIL 1
`define BIT_BIST_FAIL 0
`define BIT_ECC_DOUBLE 10
`define BIT_ECC_SINGLE 9
`define BIT_SELFTEST_TOP 8
// ---------------------------------------------
// reset values and timing
// ---------------------------------------------
`define RST_WORD 16'h0000
`define EXC_HZ_PER_UNIT 20000
`endif

// ===== hw/status_regs_pkg.sv
package status_regs_pkg;
    // ---------------------------------------------
    // grouped status carriers
    // ---------------------------------------------
    typedef struct packed {
        logic osc_fail;
        logic coil_fail;
        logic bist_fail;
    } fault_evt_t;

    typedef struct packed {
        logic double_err;
        logic single_err;
        logic [3:0] vendor_diag;
        logic [4:0] fail_addr;
    } ecc_evt_t;

    typedef struct packed {
        logic secded_fail;
        logic irq_state_fail;
        logic resonator_monitor_test_fail;
        logic gain_cmp_fail;
        logic fsm_detect_fail;
        logic current_cmp_fail;
        logic vcm_cmp_fail;
        logic second_group_test_fail;
        logic first_group_test_fail;
    } selftest_t;

    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// ===== hw/sensor_status_diagnostic_regs.sv
// Contract
// - bit 2 of 0x6D flags oscillator failure
// - bit 1 flags transmitter coil fault
// - bit 0 flags fault-detection self test failure
// - 11-bit excitation count at 0x6E, resets zero
// - count unit equals 20000 Hz by default
// - bit 10 of 0x70 flags double error
// - bit 9 of 0x70 flags corrected error
// - bits 4:0 hold last failing address
// - bits 8:5 vendor diagnostics, not relied on
// - 0x73 bits 7:4 give product version
// - 0x73 bits 3:0 give product subversion
// - 0x78 bits 6:0 give current gain code
// - 0x79 bit 8 flags checker test failure
// - bit 7 flags interrupt-state test failure
// - bit 6 flags resonator monitor test failure
// - bits 5,3,2 flag comparator test failures
// - bit 4 flags state-machine detection failure
// - bit 1 flags second group failure
// - bit 0 flags first group failure
// - writes rejected, transfer-failure flag raised
`timescale 1ns/10ps
`include "status_regs_cfg.svh"

module sensor_status_diagnostic_regs
    import status_regs_pkg::*;
#(
    parameter int COUNT_W = 11,
    parameter int GAIN_W = 7,
    parameter logic [3:0] PROD_VERSION = 4'h5,    // arbitrary value
    parameter logic [3:0] PROD_SUBVERSION = 4'h9  // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire reg_req_t req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic transfer_fail,
    input wire fault_evt_t fault_evt,
    input wire logic [COUNT_W-1:0] exc_count,
    input wire logic exc_count_valid,
    input wire ecc_evt_t ecc_evt,
    input wire logic ecc_evt_valid,
    input wire logic [GAIN_W-1:0] gain_code,
    input wire selftest_t selftest
);
    // the word layout below is built for these widths only
    if (COUNT_W != 11 || GAIN_W != 7) begin : g_bad_width
        $error("field widths fixed by register layout");
    end

    // ---------------------------------------------
    // status storage
    // ---------------------------------------------
    fault_evt_t fault_q;
    logic [COUNT_W-1:0] count_q;
    ecc_evt_t ecc_q;
    logic [GAIN_W-1:0] gain_q;
    selftest_t selftest_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q <= '0;
            count_q <= '0;
            ecc_q <= '0;
            gain_q <= '0;
            selftest_q <= '0;
        end else begin
            fault_q <= fault_evt;
            gain_q <= gain_code;
            selftest_q <= selftest;
            if (exc_count_valid) begin
                count_q <= exc_count;
            end
            if (ecc_evt_valid) begin
                ecc_q <= ecc_evt;
            end
        end
    end

    // ---------------------------------------------
    // read decode
    // ---------------------------------------------
    wire hit_irq = req.addr == `OFS_FAULT_IRQ3;
    wire hit_cnt = req.addr == `OFS_EXC_COUNT;
    wire hit_ecc = req.addr == `OFS_NVM_ECC;
    wire hit_rev = req.addr == `OFS_REVISION;
    wire hit_gain = req.addr == `OFS_GAIN_CODE;
    wire hit_st = req.addr == `OFS_SELFTEST;
    wire hit_any = hit_irq | hit_cnt | hit_ecc | hit_rev | hit_gain | hit_st;
    // reserved bits read as zero, one legal choice of "unspecified"
    wire [15:0] word_irq = {13'h0000, fault_q};
    wire [15:0] word_cnt = {5'h00, count_q};
    wire [15:0] word_ecc = {5'h00, ecc_q};
    wire [15:0] word_rev = {8'h00, PROD_VERSION, PROD_SUBVERSION};
    wire [15:0] word_gain = {9'h000, gain_q};
    wire [15:0] word_st = {7'h00, selftest_q};
    logic [15:0] word_sel;
    always_comb begin
        if (hit_irq) begin
            word_sel = word_irq;
        end else if (hit_cnt) begin
            word_sel = word_cnt;
        end else if (hit_ecc) begin
            word_sel = word_ecc;
        end else if (hit_rev) begin
            word_sel = word_rev;
        end else if (hit_gain) begin
            word_sel = word_gain;
        end else if (hit_st) begin
            word_sel = word_st;
        end else begin
            word_sel = `RST_WORD;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `RST_WORD;
            rd_valid <= 1'b0;
            transfer_fail <= 1'b0;
        end else begin
            rd_data <= req.rd ? word_sel : rd_data;
            rd_valid <= req.rd;
            transfer_fail <= req.wr & hit_any;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    a_write_flagged: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && hit_any |=> transfer_fail)
        else $error("write to status bank not flagged");
    a_osc_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_irq && fault_q.osc_fail |=> rd_data[`BIT_OSC_FAIL])
        else $error("oscillator fail bit wrong");
    a_coil_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_irq |=> rd_data[`BIT_COIL_FAIL] == $past(fault_q.coil_fail))
        else $error("coil fail bit wrong");
    a_bist_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fault_evt.bist_fail ##1 (req.rd && hit_irq) |=> rd_data[`BIT_BIST_FAIL])
        else $error("bist fail bit lost");
    a_count_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exc_count_valid ##1 (req.rd && hit_cnt && !exc_count_valid)
        |=> rd_data == {5'h00, $past(exc_count, 2)})
        else $error("excitation count readback wrong");
    a_ecc_double: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_ecc |=> rd_data[`BIT_ECC_DOUBLE] == $past(ecc_q.double_err))
        else $error("double error flag wrong");
    a_ecc_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_ecc |=> rd_data[`BIT_ECC_SINGLE] == $past(ecc_q.single_err))
        else $error("single error flag wrong");
    a_ecc_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ecc_evt_valid ##1 (req.rd && hit_ecc && !ecc_evt_valid)
        |=> rd_data[4:0] == $past(ecc_evt.fail_addr, 2))
        else $error("failing address wrong");
    a_rev_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_rev |=> rd_data[7:0] == {PROD_VERSION, PROD_SUBVERSION})
        else $error("revision code wrong");
    a_gain_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_gain |=> rd_data[6:0] == $past(gain_code, 2))
        else $error("gain code wrong");
    a_selftest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && hit_st |=> rd_data[`BIT_SELFTEST_TOP:0] == $past(selftest, 2))
        else $error("self test word wrong");
    a_read_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !req.rd |=> !rd_valid)
        else $error("spurious read valid");

    // ---------------------------------------------
    // read sequences
    // ---------------------------------------------
    // each names the request cycle; the word shows one edge later
    sequence s_irq_read;
        req.rd && hit_irq;
    endsequence

    sequence s_cnt_read;
        req.rd && hit_cnt;
    endsequence

    sequence s_ecc_read;
        req.rd && hit_ecc;
    endsequence

    sequence s_rev_read;
        req.rd && hit_rev;
    endsequence

    sequence s_gain_read;
        req.rd && hit_gain;
    endsequence

    sequence s_st_read;
        req.rd && hit_st;
    endsequence

    sequence s_miss_read;
        req.rd && !hit_any;
    endsequence

    // capture, then a read with no fresh capture in between
    sequence s_count_load;
        exc_count_valid ##1 (req.rd && hit_cnt && !exc_count_valid);
    endsequence

    sequence s_ecc_load;
        ecc_evt_valid ##1 (req.rd && hit_ecc && !ecc_evt_valid);
    endsequence

    // ---------------------------------------------
    // field checks
    // ---------------------------------------------
    a_osc_mirror: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_irq_read |=> rd_data[`BIT_OSC_FAIL] == $past(fault_q.osc_fail))
        else $error("oscillator bit not mirrored");

    a_coil_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_irq_read |=> rd_data[`BIT_COIL_FAIL] == $past(fault_evt.coil_fail, 2))
        else $error("coil bit not from input");

    a_bist_mirror: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_irq_read |=> rd_data[`BIT_BIST_FAIL] == $past(fault_q.bist_fail))
        else $error("bist bit not mirrored");

    a_count_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_count_load |=> rd_data[10:0] == $past(exc_count, 2))
        else $error("loaded count not shown");

    a_count_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !exc_count_valid |=> count_q == $past(count_q))
        else $error("count changed without valid");

    a_count_scale: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_cnt_read |=> rd_data[10:0] == $past(count_q))
        else $error("count not in plain units");

    a_ecc_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_ecc_load |=> rd_data[10:0] == $past(ecc_evt, 2))
        else $error("loaded ecc status not shown");

    a_ecc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ecc_evt_valid |=> ecc_q == $past(ecc_q))
        else $error("ecc status changed without valid");

    a_ecc_diag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_ecc_read |=> rd_data[8:5] == $past(ecc_q.vendor_diag))
        else $error("diagnostic bits not passed");

    a_rev_sub: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_rev_read |=> rd_data[3:0] == PROD_SUBVERSION)
        else $error("subversion code wrong");

    a_gain_stored: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_gain_read |=> rd_data[6:0] == $past(gain_q))
        else $error("gain code not from store");

    a_write_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(req.wr && hit_any) |=> !transfer_fail)
        else $error("transfer failure without write");

    a_valid_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd |=> rd_valid)
        else $error("read not answered");

    a_data_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !req.rd |=> rd_data == $past(rd_data))
        else $error("read word changed without read");

    // ---------------------------------------------
    // reserved bits
    // ---------------------------------------------
    // zero today; hosts must still mask, so this may be relaxed
    a_irq_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_irq_read |=> rd_data[15:3] == 13'h0000)
        else $error("irq reserved bits set");

    a_count_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_cnt_read |=> rd_data[15:11] == 5'h00)
        else $error("count reserved bits set");

    a_ecc_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_ecc_read |=> rd_data[15:11] == 5'h00)
        else $error("ecc reserved bits set");

    a_rev_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_rev_read |=> rd_data[15:8] == 8'h00)
        else $error("revision reserved bits set");

    a_gain_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_gain_read |=> rd_data[15:7] == 9'h000)
        else $error("gain reserved bits set");

    a_st_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_st_read |=> rd_data[15:9] == 7'h00)
        else $error("self test reserved bits set");

    a_miss_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_miss_read |=> rd_data == `RST_WORD)
        else $error("unmapped read not zero");

    // ---------------------------------------------
    // self-test bit checks
    // ---------------------------------------------
    for (genvar i = 0; i < 9; i++) begin : g_st_bit
        a_st_bit: assert property (
            @(posedge clk_sys) disable iff (sys_rst)
            s_st_read |=> rd_data[i] == $past(selftest_q[i]))
            else $error("self test bit wrong");
    end
endmodule // sensor_status_diagnostic_regs

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
import status_regs_pkg::*;
logic clk_sys = 1'b0;
logic sys_rst = 1'b1;
reg_req_t req = '0;
fault_evt_t fault_evt = '0;
logic [10:0] exc_count = 11'h000;
logic exc_count_valid = 1'b0;
ecc_evt_t ecc_evt = '0;
logic ecc_evt_valid = 1'b0;
logic [6:0] gain_code = 7'h00;
selftest_t selftest = '0;
logic [15:0] rd_data;
logic rd_valid;
logic transfer_fail;
int errors = 0;
int total_checks = 0;
always #5 clk_sys = ~clk_sys;
sensor_status_diagnostic_regs u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .transfer_fail(transfer_fail),
    .fault_evt(fault_evt), .exc_count(exc_count), .exc_count_valid(exc_count_valid),
    .ecc_evt(ecc_evt), .ecc_evt_valid(ecc_evt_valid), .gain_code(gain_code),
    .selftest(selftest));
// ---------------------------------------------
// bus helpers
// ---------------------------------------------
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// reserved bits are unspecified, so only the mask is compared
task automatic rd(input logic [6:0] a, input logic [15:0] m, input logic [15:0] exp);
    repeat (2) @(negedge clk_sys);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_sys);
    req.rd = 1'b0;
    chk({15'h0, rd_valid}, 16'h0001);
    chk(rd_data & m, exp);
endtask
task automatic wr(input logic [6:0] a, input logic exp);
    @(negedge clk_sys);
    req.addr = a;
    req.wr = 1'b1;
    @(negedge clk_sys);
    req.wr = 1'b0;
    chk({15'h0, transfer_fail}, {15'h0, exp});
endtask
// ---------------------------------------------
// scenarios
// ---------------------------------------------
task automatic t_reset;
    rd(7'h6d, 16'h0007, 16'h0000);
    rd(7'h6e, 16'h07ff, 16'h0000);
    rd(7'h70, 16'h061f, 16'h0000);
    rd(7'h73, 16'h00ff, 16'h0059);
    rd(7'h78, 16'h007f, 16'h0000);
    rd(7'h79, 16'h01ff, 16'h0000);
    rd(7'h10, 16'hffff, 16'h0000);
endtask
task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
        fault_evt = 3'(1 << i);
        rd(7'h6d, 16'h0007, 16'(1 << i));
    end
    fault_evt = '0;
endtask
task automatic t_count;
    exc_count = 11'h7ff;
    exc_count_valid = 1'b1;
    @(negedge clk_sys);
    exc_count_valid = 1'b0;
    exc_count = 11'h123;
    rd(7'h6e, 16'h07ff, 16'h07ff);
    exc_count = 11'h0c8;
    exc_count_valid = 1'b1;
    @(negedge clk_sys);
    exc_count_valid = 1'b0;
    rd(7'h6e, 16'h07ff, 16'h00c8);
endtask
task automatic t_ecc;
    // double set, diag 0xa, address 0x1f
    ecc_evt = 11'h55f;
    ecc_evt_valid = 1'b1;
    @(negedge clk_sys);
    // single set, diag 0x5, address 0x01
    ecc_evt = 11'h2a1;
    ecc_evt_valid = 1'b0;
    rd(7'h70, 16'h061f, 16'h041f);
    ecc_evt_valid = 1'b1;
    @(negedge clk_sys);
    ecc_evt_valid = 1'b0;
    rd(7'h70, 16'h061f, 16'h0201);
endtask
task automatic t_gain;
    gain_code = 7'h7f;
    rd(7'h78, 16'h007f, 16'h007f);
    gain_code = 7'h2a;
    rd(7'h78, 16'h007f, 16'h002a);
endtask
task automatic t_selftest;
    for (int i = 0; i < 9; i++) begin
        selftest = 9'(1 << i);
        rd(7'h79, 16'h01ff, 16'(1 << i));
    end
    selftest = '0;
endtask
task automatic t_write;
    wr(7'h6d, 1'b1);
    wr(7'h79, 1'b1);
    wr(7'h10, 1'b0);
    rd(7'h6d, 16'h0007, 16'h0000);
endtask
// stored count and ecc status must clear on a mid-run reset
task automatic t_midreset;
    rd(7'h6e, 16'h07ff, 16'h00c8);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    @(negedge clk_sys);
    chk(rd_data, 16'h0000);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    rd(7'h6e, 16'h07ff, 16'h0000);
    rd(7'h70, 16'h061f, 16'h0000);
endtask
// ---------------------------------------------
// run control
// ---------------------------------------------
task automatic finish_test;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_fault();
    t_count();
    t_ecc();
    t_gain();
    t_selftest();
    t_write();
    t_midreset();
    finish_test();
end
// about 116 cycles expected; the 2000-cycle limit is over seventeen times that, so reaching it is a hang
initial begin
    #20000;
    errors++;
    finish_test();
end
endmodule // tb
